//--- hdl/spc_power_ctrl.sv
// Socket power control and general control registers with power switch drive.
module spc_power_ctrl (
	input  wire logic                        CLK,
	input  wire logic                        RST_B,
	input  wire logic                        REG_WR,
	input  wire logic                        REG_RD,
	input  wire logic [spc_pkg::ADDR_W-1:0]  REG_ADDR,
	input  wire logic [7:0]                  REG_WDATA,
	output logic      [7:0]                  REG_RDATA,
	output logic                             REG_HIT,
	input  wire logic [7:0]                  SYS_CTRL,
	input  wire logic                        CD1_B,
	input  wire logic                        CD2_B,
	output logic                             CARD_OUT_EN,
	output spc_pkg::spc_vcc_e                VCC_SEL,
	output spc_pkg::spc_vpp_e                VPP_SEL,
	output logic                             SOCKET_POWER_STATE,
	output logic                             LEGACY_MODE,
	output logic      [7:0]                  GEN_CTRL
);
	import spc_pkg::*;

	typedef struct packed {
		logic [7:0] pwr;
		logic [7:0] gen;
		logic [3:0] rev;
		logic [1:0] emu;
		logic [1:0] vcc;
		logic [1:0] vpp;
		logic [7:0] rdata;
		logic       hit;
	} spc_state_s;

	spc_state_s st_r;
	spc_state_s st_nxt;
	logic [1:0] cd_s;
	logic       card_in;
	logic       legacy;
	logic       auto_on;
	logic       pwr_on;
	logic [1:0] vcc_req;
	logic [1:0] vcc_act;
	logic [7:0] pwr_view;
	logic [7:0] wmask;

	function automatic logic hit_at(input logic [ADDR_W-1:0] a,
		input logic [ADDR_W-1:0] idx, input logic [ADDR_W-1:0] sock);
		hit_at = (a == idx) || (a == sock);
	endfunction

	function automatic logic [7:0] merge(input logic [7:0] old,
		input logic [7:0] d, input logic [7:0] m);
		merge = (old & ~m) | (d & m);
	endfunction

	// Resets to the idle pin level so no false card follows reset.
	spc_sync2 #(.W(2), .RST_VAL('1)) u_cd_sync (
		.CLK   (CLK),
		.RST_B (RST_B),
		.d     ({CD2_B, CD1_B}),
		.q     (cd_s)
	);

	always_comb begin
		card_in  = ~cd_s[0] & ~cd_s[1];
		legacy   = (st_r.rev == REV_LEGACY); // [RQ14] [RQ16]
		auto_on  = st_r.pwr[B_AUTO] & ~legacy
			& SYS_CTRL[SYS_AUTO_BIT]; // [RQ4] [RQ5]
		if (legacy)
			vcc_req = st_r.pwr[4:3]; // [RQ10]
		else if (st_r.pwr[B_PWREN])
			vcc_req = SYS_CTRL[SYS_LEVEL_BIT] ? VCC_3V3 : VCC_5V; // [RQ6]
		else
			vcc_req = 2'h0;
		if (auto_on && !card_in)
			vcc_act = 2'h0; // [RQ4]
		else
			vcc_act = vcc_req;
		pwr_on   = (vcc_act == VCC_5V) || (vcc_act == VCC_3V3);
		wmask    = legacy ? ALT_WMASK : PRI_WMASK; // [RQ16]
		pwr_view = st_r.pwr & wmask; // [RQ3] [RQ7] [RQ11]

		st_nxt       = st_r;
		st_nxt.hit   = 1'b0;
		st_nxt.rdata = 8'h00;
		if (REG_WR) begin
			if (hit_at(REG_ADDR, IDX_PWR, SOCK_PWR))
				st_nxt.pwr = merge(st_r.pwr, REG_WDATA,
					wmask); // [RQ3] [RQ7] [RQ11] [RQ12]
			if (hit_at(REG_ADDR, IDX_GEN, SOCK_GEN))
				st_nxt.gen = REG_WDATA; // [RQ13]
			if (hit_at(REG_ADDR, IDX_REV, SOCK_REV)) begin
				st_nxt.rev = REG_WDATA[3:0]; // [RQ14]
				st_nxt.emu = REG_WDATA[5:4];
			end
		end
		if (REG_RD) begin
			if (hit_at(REG_ADDR, IDX_PWR, SOCK_PWR)) begin
				st_nxt.rdata = pwr_view;
				st_nxt.hit   = 1'b1;
			end else if (hit_at(REG_ADDR, IDX_GEN, SOCK_GEN)) begin
				st_nxt.rdata = st_r.gen;
				st_nxt.hit   = 1'b1;
			end else if (hit_at(REG_ADDR, IDX_REV, SOCK_REV)) begin
				st_nxt.rdata = {IF_TYPE, st_r.emu, st_r.rev};
				st_nxt.hit   = 1'b1;
			end
		end

		st_nxt.vcc = vcc_act;
		if (!pwr_on) begin
			st_nxt.vpp = VPP_NONE; // [RQ9]
		end else begin
			case (st_r.pwr[1:0]) // [RQ8] [RQ9]
				VPP_NONE: st_nxt.vpp = VPP_NONE;
				VPP_VCC:  st_nxt.vpp = VPP_VCC;
				VPP_12V:  st_nxt.vpp = VPP_12V;
				default:  st_nxt.vpp = st_r.vpp;
			endcase
		end
	end

	always_ff @(posedge CLK) begin
		if (!RST_B) begin
			st_r       <= '0;
			st_r.pwr   <= PWR_RESET; // [RQ12]
			st_r.gen   <= GEN_RESET; // [RQ13]
			st_r.rev   <= REV_RESET; // [RQ14]
		end else begin
			st_r <= st_nxt;
		end
	end

	always_comb begin
		case (st_r.vcc)
			VCC_5V:  VCC_SEL = SPC_VCC_5V;
			VCC_3V3: VCC_SEL = SPC_VCC_3V3;
			default: VCC_SEL = SPC_VCC_OFF;
		endcase
		case (st_r.vpp)
			VPP_VCC: VPP_SEL = SPC_VPP_VCC;
			VPP_12V: VPP_SEL = SPC_VPP_12V;
			default: VPP_SEL = SPC_VPP_OFF;
		endcase
	end

	assign CARD_OUT_EN        = st_r.pwr[B_OE]; // [RQ1]
	assign SOCKET_POWER_STATE = (st_r.vcc == VCC_5V)
		|| (st_r.vcc == VCC_3V3); // [RQ15]
	assign LEGACY_MODE        = legacy;
	assign GEN_CTRL           = st_r.gen;
	assign REG_RDATA          = st_r.rdata;
	assign REG_HIT            = st_r.hit;
endmodule // spc_power_ctrl

//--- hdl/spc_pkg.sv
// Constants and types for the socket power control register block.
// Functional notes
// RQ1: Socket outputs disabled unless card output enable set.
// RQ2: Software may clear output enable to save power.
// RQ3: Primary layout bit 6 reads zero, ignores writes.
// RQ4: Bit 5 enables automatic power switching from detects.
// RQ5: Auto switching works only with system bit 7.
// RQ6: Power enable gates Vcc, level from system bit.
// RQ7: Primary layout bits 3 and 2 read zero.
// RQ8: Vpp request: none, Vcc, 12 V, reserved.
// RQ9: Vpp request ignored unless Vcc is on.
// RQ10: Alternate layout Vcc request in bits 4-3.
// RQ11: Alternate layout bits 6, 5, 2 read zero.
// RQ12: Power control at index 02h/802h, resets 00h.
// RQ13: General control at index 03h/803h, all read/write.
// RQ14: Revision field 0010b selects legacy mode; resets 0100b.
// RQ15: Power status reads one when Vcc/Vpp on.
// RQ16: Alternate layout in legacy mode, primary otherwise.
package spc_pkg;
	localparam int          ADDR_W        = 12;
	localparam logic [11:0] IDX_PWR       = 12'h002;
	localparam logic [11:0] IDX_GEN       = 12'h003;
	localparam logic [11:0] SOCK_PWR      = 12'h802;
	localparam logic [11:0] SOCK_GEN      = 12'h803;
	localparam logic [11:0] IDX_REV       = 12'h000;
	localparam logic [11:0] SOCK_REV      = 12'h800;
	localparam logic [7:0]  PWR_RESET     = 8'h00;
	localparam logic [7:0]  GEN_RESET     = 8'h00;
	localparam logic [3:0]  REV_RESET     = 4'h4;
	localparam logic [3:0]  REV_LEGACY    = 4'h2;
	localparam logic [1:0]  IF_TYPE       = 2'h2;
	localparam int          B_OE          = 7;
	localparam int          B_AUTO        = 5;
	localparam int          B_PWREN       = 4;
	localparam int          SYS_AUTO_BIT  = 7;
	localparam int          SYS_LEVEL_BIT = 2;
	localparam logic [7:0]  PRI_WMASK     = 8'hb3;
	localparam logic [7:0]  ALT_WMASK     = 8'h9b;
	localparam logic [1:0]  VPP_NONE      = 2'h0;
	localparam logic [1:0]  VPP_VCC       = 2'h1;
	localparam logic [1:0]  VPP_12V       = 2'h2;
	localparam logic [1:0]  VCC_5V        = 2'h2;
	localparam logic [1:0]  VCC_3V3       = 2'h3;
	typedef enum logic [1:0] {SPC_VCC_OFF, SPC_VCC_5V, SPC_VCC_3V3} spc_vcc_e;
	typedef enum logic [1:0] {SPC_VPP_OFF, SPC_VPP_VCC, SPC_VPP_12V} spc_vpp_e;
endpackage : spc_pkg

//--- hdl/spc_sync2.sv
// Two flip-flop synchroniser for a bus of level inputs.
module spc_sync2 #(
	parameter int           W       = 2,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input  wire logic         CLK,
	input  wire logic         RST_B,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} spc_sync_s;
	spc_sync_s st_r;
	spc_sync_s st_nxt;

	if (W < 1) begin : g_bad_width
		$error("spc_sync2 width must be positive");
	end

	always_comb begin
		st_nxt.s1 = d;
		st_nxt.s2 = st_r.s1;
	end

	always_ff @(posedge CLK) begin
		if (!RST_B)
			st_r <= {RST_VAL, RST_VAL};
		else
			st_r <= st_nxt;
	end

	assign q = st_r.s2;
endmodule // spc_sync2

//--- tb/spc_socket_model.sv
// Card socket model driving both card detect pins.
module spc_socket_model (
	input  wire logic inserted,
	output logic      cd1_b,
	output logic      cd2_b
);
	timeunit 1ns;
	timeprecision 1ps;
	assign cd1_b = !inserted;
	assign cd2_b = !inserted;
endmodule // spc_socket_model

//--- tb/spc_power_ctrl_properties.sv
// Port assertions for the socket power control block.
module spc_power_ctrl_properties
	import spc_pkg::*;
(
	input wire logic              CLK,
	input wire logic              RST_B,
	input wire logic              REG_WR,
	input wire logic              REG_RD,
	input wire logic [ADDR_W-1:0] REG_ADDR,
	input wire logic [7:0]        REG_WDATA,
	input wire logic [7:0]        REG_RDATA,
	input wire logic              REG_HIT,
	input wire logic              CARD_OUT_EN,
	input wire spc_vcc_e          VCC_SEL,
	input wire spc_vpp_e          VPP_SEL,
	input wire logic              SOCKET_POWER_STATE,
	input wire logic              LEGACY_MODE,
	input wire logic [7:0]        GEN_CTRL
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge CLK); endclocking
	default disable iff (!RST_B);
	a_gen_hit: assert property (
		REG_RD && REG_ADDR == SOCK_GEN |=> REG_HIT)
		else $error("general read not mapped");
	a_rd_idle: assert property (
		!REG_RD |=> REG_RDATA == 8'h00 && !REG_HIT)
		else $error("read data without read");
	a_oe_follow: assert property (REG_WR && REG_ADDR == IDX_PWR
		|=> CARD_OUT_EN == $past(REG_WDATA[B_OE])) else $error("output enable");
	a_oe_sock: assert property (REG_WR && REG_ADDR == SOCK_PWR
		|=> CARD_OUT_EN == $past(REG_WDATA[B_OE]))
		else $error("socket offset write lost");
	a_gen_store: assert property (REG_WR && REG_ADDR == SOCK_GEN
		|=> GEN_CTRL == $past(REG_WDATA)) else $error("general write lost");
	a_vpp_gate: assert property (
		VCC_SEL == SPC_VCC_OFF |-> VPP_SEL == SPC_VPP_OFF)
		else $error("vpp on without vcc");
	a_pwr_state: assert property (
		SOCKET_POWER_STATE == (VCC_SEL != SPC_VCC_OFF))
		else $error("power state wrong");
	a_pri_zero: assert property (
		REG_RD && REG_ADDR == IDX_PWR && !LEGACY_MODE
		|=> (REG_RDATA & 8'h4c) == 8'h00) else $error("primary zero bits");
	a_alt_zero: assert property (
		REG_RD && REG_ADDR == IDX_PWR && LEGACY_MODE
		|=> (REG_RDATA & 8'h64) == 8'h00) else $error("alternate zero bits");
endmodule // spc_power_ctrl_properties
bind spc_power_ctrl spc_power_ctrl_properties u_props (.CLK, .RST_B, .REG_WR,
	.REG_RD, .REG_ADDR, .REG_WDATA, .REG_RDATA, .REG_HIT, .CARD_OUT_EN,
	.VCC_SEL, .VPP_SEL, .SOCKET_POWER_STATE, .LEGACY_MODE, .GEN_CTRL);

//--- tb/tb.sv
// Self-checking bench for the socket power control block.
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import spc_pkg::*;
	logic clk, rst_b, reg_wr, reg_rd, hit, oe, pst, leg, ins, cd1_b, cd2_b;
	logic [11:0] reg_addr;
	logic [7:0]  reg_wdata, rdata, sys, gen;
	spc_vcc_e    vcc;
	spc_vpp_e    vpp;
	int          mismatches = 0;
	int          checks_done = 0;
	spc_socket_model u_sock (.inserted(ins), .cd1_b(cd1_b), .cd2_b(cd2_b));
	spc_power_ctrl DUT (.CLK(clk), .RST_B(rst_b), .REG_WR(reg_wr),
		.REG_RD(reg_rd), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
		.REG_RDATA(rdata), .REG_HIT(hit), .SYS_CTRL(sys), .CD1_B(cd1_b),
		.CD2_B(cd2_b), .CARD_OUT_EN(oe), .VCC_SEL(vcc), .VPP_SEL(vpp),
		.SOCKET_POWER_STATE(pst), .LEGACY_MODE(leg), .GEN_CTRL(gen));
	initial begin
		clk = 0;
		forever #2 clk = ~clk;
	end
	task chk(input string n, input logic [7:0] s, input logic [7:0] e);
		checks_done++;
		if (s !== e) begin
			mismatches++;
			$display("MISMATCH %s exp %h seen %h", n, e, s);
		end
	endtask
	task put_reg(input logic [11:0] a, input logic [7:0] d);
		@(posedge clk) #1 reg_wr = 1;
		reg_addr = a;
		reg_wdata = d;
		@(posedge clk) #1 reg_wr = 0;
		repeat (4) @(posedge clk);
		#1;
	endtask
	task get_reg(input logic [11:0] a, input logic [7:0] e, input logic h);
		@(posedge clk) #1 reg_rd = 1;
		reg_addr = a;
		@(posedge clk) #1 reg_rd = 0;
		chk("rdata", rdata, e);
		chk("hit", hit, h);
	endtask
	task t_reset;
		get_reg(IDX_PWR, 8'h00, 1);
		get_reg(SOCK_GEN, 8'h00, 1);
		get_reg(IDX_REV, 8'h84, 1);
		get_reg(12'h004, 8'h00, 0);
		chk("oe", oe, 0);
	endtask
	task t_primary;
		put_reg(IDX_PWR, 8'hff);
		get_reg(SOCK_PWR, 8'hb3, 1);
		chk("oe", oe, 1);
		chk("vcc", vcc, SPC_VCC_5V);
		chk("vpp", vpp, SPC_VPP_OFF);
		sys = 8'h84;
		put_reg(IDX_PWR, 8'hb0);
		chk("vcc", vcc, SPC_VCC_OFF);
		chk("pst", pst, 0);
		ins = 1;
		put_reg(IDX_PWR, 8'h30);
		chk("vcc", vcc, SPC_VCC_3V3);
		put_reg(IDX_PWR, 8'h12);
		chk("oe", oe, 0);
		chk("vcc", vcc, SPC_VCC_3V3);
		chk("vpp", vpp, SPC_VPP_12V);
		chk("pst", pst, 1);
		put_reg(IDX_PWR, 8'h13);
		chk("vpp", vpp, SPC_VPP_12V);
		put_reg(IDX_PWR, 8'h11);
		chk("vpp", vpp, SPC_VPP_VCC);
		put_reg(IDX_PWR, 8'h02);
		chk("vpp", vpp, SPC_VPP_OFF);
	endtask
	task t_gen;
		put_reg(SOCK_GEN, 8'ha5);
		get_reg(IDX_GEN, 8'ha5, 1);
		chk("gen", gen, 8'ha5);
	endtask
	task t_legacy;
		put_reg(IDX_REV, 8'h02);
		chk("leg", leg, 1);
		put_reg(SOCK_PWR, 8'hff);
		get_reg(IDX_PWR, 8'h9b, 1);
		chk("vcc", vcc, SPC_VCC_3V3);
		put_reg(IDX_PWR, 8'h10);
		chk("vcc", vcc, SPC_VCC_5V);
		put_reg(IDX_PWR, 8'h08);
		chk("vcc", vcc, SPC_VCC_OFF);
	endtask
	task t_mid_reset;
		@(posedge clk) #1 rst_b = 0;
		repeat (3) @(posedge clk);
		#1 rst_b = 1;
		chk("oe", oe, 0);
		chk("vcc", vcc, SPC_VCC_OFF);
		chk("leg", leg, 0);
		chk("gen", gen, 8'h00);
		get_reg(IDX_PWR, 8'h00, 1);
		get_reg(SOCK_REV, 8'h84, 1);
	endtask
	task give_verdict;
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial begin
		#100000;
		mismatches++;
		give_verdict;
	end
	initial begin
		{rst_b, reg_wr, reg_rd, reg_addr, reg_wdata, sys, ins} = '0;
		repeat (20) @(posedge clk);
		#1 rst_b = 1;
		t_reset;
		t_primary;
		t_gen;
		t_legacy;
		t_mid_reset;
		give_verdict;
	end
endmodule // tb
